// file: src/sccu_pkg.sv
// shared constants and types of the sixteen channel capture/compare unit
package sccu_pkg;
  // channel count and timer width
  localparam int NCH = 16;
  localparam int NPAIR = 8;
  localparam int TW = 16;
  localparam int PRESC_W = 8;
  // time base limits and reset values
  localparam logic [TW-1:0] TIMER_RST = 16'h0000;
  localparam logic [TW-1:0] TIMER_MAX = 16'hffff;
  localparam logic [TW-1:0] VALUE_RST = 16'h0000;
  // staggered mode widens the smallest prescaler step to eight cycles
  localparam logic [PRESC_W-1:0] STAGGER_MASK = 8'h07;
  // capture edge selection bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // compare modes
  localparam logic [1:0] CMP_MODE0 = 2'h0;
  localparam logic [1:0] CMP_MODE1 = 2'h1;
  localparam logic [1:0] CMP_MODE2 = 2'h2;
  localparam logic [1:0] CMP_MODE3 = 2'h3;
  // mode bit that marks the once-per-period modes 2 and 3
  localparam int ONCE_BIT = 1;
  // clock source of a time base
  typedef enum logic [1:0] {SRC_PRESC, SRC_GPT, SRC_EXT} sccu_src_t;
endpackage

// file: src/sccu_tb_if.sv
// carrier between the unit and one of its time base timers
`timescale 1ns/1ps
`default_nettype none
interface sccu_tb_if;
  import sccu_pkg::*;
  sccu_src_t clkSel;          // clock source
  logic [2:0] prescExp;       // prescaler factor is two to this power
  logic [TW-1:0] reload;      // reload value
  logic run;                  // counting enable
  logic stagger;              // staggered mode
  logic gptOvf;               // overflow pulse of the general overflow timer
  logic extTick;              // filtered external count event
  logic [TW-1:0] value;       // current count
  logic countPulse;           // value changed in the previous cycle
  logic ovfPulse;             // value was reloaded in the previous cycle
  modport tb (input clkSel, prescExp, reload, run, stagger, gptOvf,
    extTick, output value, countPulse, ovfPulse);
  modport user (output clkSel, prescExp, reload, run, stagger, gptOvf,
    extTick, input value, countPulse, ovfPulse);
endinterface
`default_nettype wire

// file: src/sccu_time_base.sv
// one 16-bit time base timer with prescaler and reload
`timescale 1ns/1ps
`default_nettype none
module sccu_time_base (
  // clock and synchronised reset
  input wire logic sysClk,
  input wire logic rstnSync,
  // configuration and count towards the channel array
  sccu_tb_if.tb tb
);
  import sccu_pkg::*;

  typedef struct packed {
    logic [PRESC_W-1:0] presc;  // free running prescaler
    logic [TW-1:0] cnt;         // timer count
    logic count;                // count happened
    logic ovf;                  // overflow happened
  } sccu_tbst_t;

  sccu_tbst_t q;
  sccu_tbst_t d;
  logic tick;

  // prescaler mask: stagger never lets a step fall below eight cycles
  function automatic logic [PRESC_W-1:0] prescMask(logic [2:0] e,
    logic stg);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((9'h001 << e) - 9'h001);
    if (stg)
    begin
      m = m | STAGGER_MASK;
    end
    return m;
  endfunction

  // next state: source select, count and reload
  always_comb
  begin
    d = q;
    d.count = 1'b0;
    d.ovf = 1'b0;
    d.presc = q.presc + 8'h01;
    case (tb.clkSel)
      SRC_PRESC: tick = (q.presc & prescMask(tb.prescExp, tb.stagger)) ==
        prescMask(tb.prescExp, tb.stagger);
      SRC_GPT: tick = tb.gptOvf;
      SRC_EXT: tick = tb.extTick;
      default: tick = 1'b0;
    endcase
    if (tb.run && tick)
    begin
      d.count = 1'b1;
      if (q.cnt == TIMER_MAX)
      begin
        // overflow restarts from the reload value
        d.cnt = tb.reload;
        d.ovf = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge sysClk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      q <= '{presc: '0, cnt: TIMER_RST, count: 1'b0, ovf: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign tb.value = q.cnt;
  assign tb.countPulse = q.count;
  assign tb.ovfPulse = q.ovf;

  reload_load_a: assert property (
    @(posedge sysClk) disable iff (!rstnSync)
    tb.ovfPulse |-> tb.value == $past(tb.reload))
    else $error("timer did not restart from reload value");

  // the count that opens the window must itself come from a staggered tick
  stagger_step_a: assert property (
    @(posedge sysClk) disable iff (!rstnSync)
    (tb.countPulse && tb.stagger && $past(tb.stagger) &&
    tb.clkSel == SRC_PRESC && $past(tb.clkSel) == SRC_PRESC) |=>
    !tb.countPulse [*7])
    else $error("staggered count faster than eight cycles");
endmodule
`default_nettype wire

// file: src/sccu_top.sv
// sixteen channel capture/compare unit with two time bases
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - one cycle resolution, eight when staggered
// - two independent 16-bit timers with reload
// - timers clocked by prescaler or overflow timer
// - first timer takes an external count input
// - sixteen registers, timer and function chosen
// - each register owns one pin, bar the upper one of a pair
// - mode 0: interrupt only, several per period
// - mode 1: pin toggles on every match
// - mode 2: interrupt only, once per period
// - mode 3: set on match, clear on overflow
// - double register: two registers toggle one pin
// - single event option for any compare mode
// - capture latches assigned timer on pin event
// - capture raises the channel interrupt
// - capture edge rising, falling or both
// - compare on every count, act on equality
module sccu_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // time base configuration, index 0 is the first time base
  input wire sccu_pkg::sccu_src_t tbClkSel [2],
  input wire logic [1:0][2:0] tbPrescExp,
  input wire logic [1:0][sccu_pkg::TW-1:0] tbReload,
  input wire logic [1:0] tbRun,
  input wire logic staggerEn,
  // count sources
  input wire logic gptOverflow,
  input wire logic firstBaseCountPin,
  // channel configuration
  input wire logic [sccu_pkg::NCH-1:0] chCapture,
  input wire logic [sccu_pkg::NCH-1:0] chTimerSel,
  input wire logic [sccu_pkg::NCH-1:0][1:0] chMode,
  input wire logic [sccu_pkg::NCH-1:0][1:0] chEdge,
  input wire logic [sccu_pkg::NCH-1:0] chSingle,
  input wire logic [sccu_pkg::NPAIR-1:0] chPairEn,
  // software write of channel values
  input wire logic [sccu_pkg::NCH-1:0] chWrite,
  input wire logic [sccu_pkg::TW-1:0] chWriteData,
  // channel pins
  input wire logic [sccu_pkg::NCH-1:0] chPinIn,
  output logic [sccu_pkg::NCH-1:0] chPinOut,
  output logic [sccu_pkg::NCH-1:0] chPinOe,
  // channel state
  output logic [sccu_pkg::NCH-1:0][sccu_pkg::TW-1:0] chValue,
  output logic [sccu_pkg::NCH-1:0] chIrq,
  // time base state
  output logic [1:0][sccu_pkg::TW-1:0] timerValue,
  output logic [1:0] timerOvf
);
  import sccu_pkg::*;

  typedef struct packed {
    logic [NCH-1:0] s1;           // pin synchroniser, first stage
    logic [NCH-1:0] s2;           // second stage
    logic [NCH-1:0] s3;           // third stage
    logic [NCH-1:0] lvl;          // accepted pin level
    logic [2:0] ext;              // external count synchroniser
    logic extLvl;                 // accepted external count level
    logic extTick;                // external rising edge, one cycle
    logic [NCH-1:0] pin;          // pin output latches
    logic [NCH-1:0][TW-1:0] value; // capture/compare registers
    logic [NCH-1:0] irq;          // interrupt pulses
    logic [NCH-1:0] done;         // event taken this period
    logic [NCH-1:0] armed;        // single event not yet spent
  } sccu_st_t;

  sccu_st_t q;
  sccu_st_t d;
  logic [1:0] rstSync;            // reset release synchroniser
  logic rstnSync;

  // per channel helpers, also watched by the checks below
  logic [NCH-1:0] capEv;
  logic [NCH-1:0] match;
  logic [NCH-1:0] pinTog;
  logic [NCH-1:0] setPin;
  logic [NCH-1:0] clrPin;
  logic [NCH-1:0][TW-1:0] selVal;
  logic [NCH-1:0] selCnt;
  logic [NCH-1:0] selOvf;

  sccu_tb_if tbIf [2] ();

  // reset is released through two flip-flops, asserted at once
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnSync = rstSync[1];

  // two time bases of one design
  for (genvar t = 0; t < 2; t++)
  begin : g_base
    assign tbIf[t].clkSel = tbClkSel[t];
    assign tbIf[t].prescExp = tbPrescExp[t];
    assign tbIf[t].reload = tbReload[t];
    assign tbIf[t].run = tbRun[t];
    assign tbIf[t].stagger = staggerEn;
    assign tbIf[t].gptOvf = gptOverflow;
    // only the first time base sees the external count
    assign tbIf[t].extTick = (t == 0) ? q.extTick : 1'b0;
    assign timerValue[t] = tbIf[t].value;
    assign timerOvf[t] = tbIf[t].ovfPulse;
    sccu_time_base u_sccu_time_base (
      .sysClk(sys_clk),
      .rstnSync(rstnSync),
      .tb(tbIf[t])
    );
  end

  // per channel view of the assigned time base
  for (genvar c = 0; c < NCH; c++)
  begin : g_sel
    assign selVal[c] = chTimerSel[c] ? tbIf[1].value : tbIf[0].value;
    assign selCnt[c] = chTimerSel[c] ? tbIf[1].countPulse :
      tbIf[0].countPulse;
    assign selOvf[c] = chTimerSel[c] ? tbIf[1].ovfPulse :
      tbIf[0].ovfPulse;
  end

  // pin that a channel drives: a paired upper channel uses its partner's
  function automatic int pinOf(int c, logic [NPAIR-1:0] pairs);
    if (c >= NPAIR && pairs[c-NPAIR])
    begin
      return c - NPAIR;
    end
    return c;
  endfunction

  // next state of the channel array
  always_comb
  begin
    d = q;
    capEv = '0;
    match = '0;
    pinTog = '0;
    setPin = '0;
    clrPin = '0;
    d.irq = '0;
    // synchronisers; the first stage feeds the second and nothing else
    d.s1 = chPinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.ext = {q.ext[1:0], firstBaseCountPin};
    // a change is accepted once stages two and three agree
    d.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
    if (q.ext[1] == q.ext[2])
    begin
      d.extLvl = q.ext[2];
    end
    d.extTick = d.extLvl & ~q.extLvl;
    for (int c = 0; c < NCH; c++)
    begin
      // the period limit is re-armed first so a new match may set it
      if (selOvf[c])
      begin
        d.done[c] = 1'b0;
      end
      // software write loads the register and re-arms single events
      if (chWrite[c])
      begin
        d.value[c] = chWriteData;
        d.armed[c] = 1'b1;
      end
      if (chCapture[c])
      begin
        // capture on the selected pin edge
        capEv[c] = (chEdge[c][EDGE_RISE_BIT] & d.lvl[c] & ~q.lvl[c]) |
          (chEdge[c][EDGE_FALL_BIT] & ~d.lvl[c] & q.lvl[c]);
        if (capEv[c])
        begin
          // a capture wins over a write in the same cycle
          d.value[c] = selVal[c];
          d.irq[c] = 1'b1;
        end
      end
      else
      begin
        // compare on each count of the assigned timer
        match[c] = selCnt[c] && q.armed[c] && q.value[c] == selVal[c] &&
          !(chMode[c][ONCE_BIT] && q.done[c] && !selOvf[c]);
        // mode 3 pin falls back on overflow of its timer
        if (chMode[c] == CMP_MODE3 && selOvf[c])
        begin
          clrPin[pinOf(c, chPairEn)] = 1'b1;
        end
        if (match[c])
        begin
          d.irq[c] = 1'b1;
          if (chSingle[c])
          begin
            d.armed[c] = 1'b0;
          end
          case (chMode[c])
            CMP_MODE0: ; // interrupt only, pin untouched
            CMP_MODE1: pinTog[pinOf(c, chPairEn)] = 1'b1;
            CMP_MODE2: d.done[c] = 1'b1;
            CMP_MODE3:
            begin
              setPin[pinOf(c, chPairEn)] = 1'b1;
              d.done[c] = 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
    // pin latches: set beats clear beats toggle; a pair toggles once
    for (int p = 0; p < NCH; p++)
    begin
      if (setPin[p])
      begin
        d.pin[p] = 1'b1;
      end
      else if (clrPin[p])
      begin
        d.pin[p] = 1'b0;
      end
      else if (pinTog[p])
      begin
        d.pin[p] = ~q.pin[p];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      q <= '{s1: '0, s2: '0, s3: '0, lvl: '0, ext: 3'h0, extLvl: 1'b0,
        extTick: 1'b0, pin: '0, value: '0, irq: '0, done: '0,
        armed: '1};
    end
    else
    begin
      q <= d;
    end
  end

  // outputs; a compare channel drives its own pin unless it is the
  // upper half of a pair, whose events land on the partner pin
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      chPinOe[c] = !chCapture[c] && pinOf(c, chPairEn) == c;
    end
  end
  assign chPinOut = q.pin;
  assign chValue = q.value;
  assign chIrq = q.irq;

  // checks, one set per channel
  for (genvar g = 0; g < NCH; g++)
  begin : g_chk
    capture_latch_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      capEv[g] |=> chValue[g] == $past(selVal[g]))
      else $error("capture did not latch the timer value");

    capture_irq_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      capEv[g] |=> chIrq[g])
      else $error("capture raised no interrupt");

    compare_hit_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (!chCapture[g] && selCnt[g] && q.armed[g] && !q.done[g] &&
      chValue[g] == selVal[g]) |=> chIrq[g])
      else $error("compare match raised no interrupt");

    mode0_pin_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (match[g] && chMode[g] == CMP_MODE0 && !pinTog[g] && !setPin[g] &&
      !clrPin[g]) |=> $stable(chPinOut[g]))
      else $error("interrupt-only compare moved the pin");

    toggle_pin_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (pinTog[g] && !setPin[g] && !clrPin[g]) |=>
      chPinOut[g] != $past(chPinOut[g]))
      else $error("toggle match left the pin unchanged");

    once_period_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (q.done[g] && chMode[g][ONCE_BIT] && !chCapture[g] && !selOvf[g])
      |=> !chIrq[g])
      else $error("second event within one period");

    mode3_pin_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (setPin[g] |=> chPinOut[g]) and
      ((clrPin[g] && !setPin[g]) |=> !chPinOut[g]))
      else $error("mode 3 pin not set on match or cleared on overflow");

    single_event_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (match[g] && chSingle[g] && !chWrite[g]) ##1 !chWrite[g] |->
      !match[g] ##1 !match[g])
      else $error("single event compare fired again");

    capture_pin_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      chCapture[g] |-> !chPinOe[g])
      else $error("capture pin driven by the unit");

    no_edge_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (chCapture[g] && chEdge[g] == 2'h0 && !chWrite[g]) |=>
      $stable(chValue[g]))
      else $error("capture with no edge selected");

    count_only_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (!chCapture[g] && !selCnt[g]) |=> !chIrq[g])
      else $error("compare interrupt without a timer count");

    period_rearm_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (!chCapture[g] && selOvf[g] && !match[g]) |=> !q.done[g])
      else $error("overflow did not re-arm the period limit");
  end

  // an upper paired channel moves the shared lower pin
  for (genvar g = 0; g < NPAIR; g++)
  begin : g_pair_chk
    pair_toggle_a: assert property (
      @(posedge sys_clk) disable iff (!rstnSync)
      (chPairEn[g] && match[g+NPAIR] && chMode[g+NPAIR] == CMP_MODE1 &&
      !setPin[g] && !clrPin[g]) |=>
      chPinOut[g] != $past(chPinOut[g]))
      else $error("paired compare match left the shared pin unchanged");
  end

  // the external count steps the first base and never the second
  ext_count_a: assert property (
    @(posedge sys_clk) disable iff (!rstnSync)
    (q.extTick && tbRun[0] && tbClkSel[0] == SRC_EXT &&
    timerValue[0] != TIMER_MAX) |=>
    timerValue[0] == $past(timerValue[0]) + 16'h0001)
    else $error("external count did not step the first time base");

  ext_second_a: assert property (
    @(posedge sys_clk) disable iff (!rstnSync)
    tbClkSel[1] == SRC_EXT |=> $stable(timerValue[1]))
    else $error("second time base counted external events");
endmodule
`default_nettype wire

// file: sim/sccu_pin_model.sv
// model of the outside world on the channel pins
`timescale 1ns/1ps
`default_nettype none
module sccu_pin_model
  import sccu_pkg::*;
(
  // levels the outside world puts on pins that the unit leaves free
  input wire logic [sccu_pkg::NCH-1:0] extLevel,
  // pin drivers of the unit
  input wire logic [sccu_pkg::NCH-1:0] pinOut,
  input wire logic [sccu_pkg::NCH-1:0] pinOe,
  // level on each pin as the unit sees it
  output logic [sccu_pkg::NCH-1:0] pinLevel
);
  // a driven pin shows the latch, a free pin shows the outside level
  always_comb
  begin
    pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sccu_pkg::*;
  // clock, reset and time base controls
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  sccu_src_t tbClkSel [2];
  logic [1:0][2:0] tbPrescExp;
  logic [1:0][TW-1:0] tbReload, timerValue;
  logic [1:0] tbRun, timerOvf;
  logic staggerEn, gptOverflow, firstBaseCountPin;
  // channel controls and results
  logic [NCH-1:0] chCapture, chTimerSel, chSingle, chWrite, chIrq;
  logic [NCH-1:0][1:0] chMode, chEdge;
  logic [NPAIR-1:0] chPairEn;
  logic [TW-1:0] chWriteData, stamp;
  logic [NCH-1:0] chPinIn, chPinOut, chPinOe, extPin;
  logic [NCH-1:0][TW-1:0] chValue;
  // bookkeeping: interrupt pulses per channel, one nibble each
  logic [NCH-1:0][3:0] irqCnt = '0;
  logic [TW-1:0] stepExp [3] = '{16'h0050, 16'h0014, 16'h000a};
  int ovfCnt = 0;
  int errors = 0;
  int nTests = 0;
  int k;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  sccu_top u_sccu_top (.sys_clk(sys_clk), .resetn(resetn),
    .tbClkSel(tbClkSel), .tbPrescExp(tbPrescExp), .tbReload(tbReload),
    .tbRun(tbRun), .staggerEn(staggerEn), .gptOverflow(gptOverflow),
    .firstBaseCountPin(firstBaseCountPin), .chCapture(chCapture),
    .chTimerSel(chTimerSel), .chMode(chMode), .chEdge(chEdge),
    .chSingle(chSingle), .chPairEn(chPairEn), .chWrite(chWrite),
    .chWriteData(chWriteData), .chPinIn(chPinIn), .chPinOut(chPinOut),
    .chPinOe(chPinOe), .chValue(chValue), .chIrq(chIrq),
    .timerValue(timerValue), .timerOvf(timerOvf));

  sccu_pin_model u_sccu_pin_model (.extLevel(extPin), .pinOut(chPinOut),
    .pinOe(chPinOe), .pinLevel(chPinIn));

  // counts interrupt pulses and overflows of the second base
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < NCH; i++)
      if (chIrq[i] === 1'b1)
        irqCnt[i] <= irqCnt[i] + 4'h1;
    if (timerOvf[1] === 1'b1)
      ovfCnt <= ovfCnt + 1;
  end

  // closing report, also reached when a wait runs out
  task automatic giveVerdict();
    if (errors == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one compare for every kind of value, zero extended
  task automatic chk(input string name, input logic [63:0] e,
    input logic [63:0] g);
    nTests++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // n one-cycle overflow pulses of the general timer, one cycle apart
  task automatic gpt(input int n);
    repeat (n)
    begin
      gptOverflow = 1'b1;
      tick(1);
      gptOverflow = 1'b0;
      tick(1);
    end
  endtask

  // one-cycle software write to the channels in the mask
  task automatic wr(input logic [15:0] m, input logic [15:0] d);
    chWrite = m;
    chWriteData = d;
    tick(1);
    chWrite = '0;
    tick(1);
  endtask

  // main sequence
  initial
  begin
    tbClkSel[0] = SRC_GPT;
    tbClkSel[1] = SRC_GPT;
    tbPrescExp = '0;
    tbReload = {16'hfff0, 16'h0000};
    tbRun = 2'b00;
    staggerEn = 1'b0;
    gptOverflow = 1'b0;
    firstBaseCountPin = 1'b0;
    chCapture = 16'h000d;
    chTimerSel = 16'h0004;
    chMode = '0;
    chEdge = 32'h0000_00b1;
    chSingle = '0;
    chPairEn = '0;
    chWrite = '0;
    chWriteData = '0;
    extPin = '0;
    tick(20);
    resetn = 1'b1;
    tick(3);
    chk("reset", '0, {timerValue, chPinOut, chIrq});
    chk("values", '0, chValue[3:0]);
    chk("ovf", '0, timerOvf);
    // stopped base ignores pulses, running bases count them
    tbRun = 2'b01;
    gpt(3);
    tbRun = 2'b11;
    gpt(2);
    tick(2);
    chk("timers", 32'h0002_0005, timerValue);
    // external count pin drives the first base only
    tbClkSel[0] = SRC_EXT;
    tbClkSel[1] = SRC_EXT;
    repeat (3)
    begin
      firstBaseCountPin = 1'b1;
      tick(4);
      firstBaseCountPin = 1'b0;
      tick(4);
    end
    tick(4);
    chk("timer0", 16'h0008, timerValue[0]);
    chk("timer1", 16'h0002, timerValue[1]);
    // rising then falling pins on the capture channels
    extPin = 16'h000d;
    tick(8);
    chk("capRise", 64'h0000_0002_0000_0008, chValue[3:0]);
    extPin = '0;
    tick(8);
    chk("capFall", 64'h0008_0002_0000_0008, chValue[3:0]);
    chk("capIrq", 64'h1201, irqCnt);
    // prescaled steps over 80 cycles: plain, factor four, staggered
    tbClkSel[0] = SRC_PRESC;
    for (k = 0; k < 3; k++)
    begin
      tbPrescExp[0] = (k == 1) ? 3'h2 : 3'h0;
      staggerEn = (k == 2);
      tick(16);
      stamp = timerValue[0];
      tick(80);
      chk("steps", stepExp[k], timerValue[0] - stamp);
    end
    tbRun[0] = 1'b0;
    staggerEn = 1'b0;
    // second base runs to its overflow, then steps by pulses to reload
    tbClkSel[1] = SRC_PRESC;
    for (k = 0; k < 70000 && ovfCnt == 0; k++)
      tick(1);
    tbClkSel[1] = SRC_GPT;
    for (k = 0; k < 20 && ovfCnt < 2; k++)
      gpt(1);
    if (ovfCnt != 2)
    begin
      errors++;
      giveVerdict();
    end
    tick(3);
    chk("reload", 16'hfff0, timerValue[1]);
    // modes 0..3 on channels 4..7, pair 1/9, single event on 10
    chTimerSel = 16'h06f6;
    chMode = 32'h0014_e404;
    chSingle = 16'h0400;
    chPairEn = 8'h02;
    wr(16'h04f0, 16'hfff3);
    wr(16'h0002, 16'hfff2);
    wr(16'h0200, 16'hfff5);
    chk("oe", 16'hfdf2, chPinOe);
    gpt(3);
    tick(3);
    chk("pins", 16'h04a2, chPinOut & 16'h04f2);
    chk("irqs", 64'h0000_0100_1111_1211, irqCnt);
    // second match in the same period
    wr(16'h00f0, 16'hfff6);
    gpt(3);
    tick(3);
    chk("pins", 16'h0480, chPinOut & 16'h04f2);
    chk("irqs", 64'h0000_0110_1122_1211, irqCnt);
    // overflow clears the mode 3 pin
    gpt(10);
    tick(3);
    chk("wrap", 16'hfff0, timerValue[1]);
    chk("pins", 16'h0400, chPinOut & 16'h04f2);
    // next period: limits re-armed, single event stays quiet
    gpt(6);
    tick(3);
    chk("pins", 16'h04a0, chPinOut & 16'h04f2);
    chk("irqs", 64'h0000_0120_2233_1221, irqCnt);
    // a write re-arms the single event
    wr(16'h0400, 16'hfff8);
    gpt(2);
    tick(3);
    chk("pins", 16'h00a0, chPinOut & 16'h04f2);
    chk("irqs", 64'h0000_0220_2233_1221, irqCnt);
    giveVerdict();
  end
endmodule
`default_nettype wire
